// file: inc/spimsc_pkg.sv
`default_nettype none
package spimsc_pkg;
  localparam int SPIMSC_DATA_W = 8;
  localparam int SPIMSC_NUM_CS = 4;
  localparam int SPIMSC_BUF_DEPTH = 2;
  localparam logic [7:0] SPIMSC_DIV_MIN = 8'h01;
  localparam logic [7:0] SPIMSC_CNT_STEP = 8'h01;
  localparam logic [3:0] SPIMSC_CS_IDLE = 4'hF;
  localparam logic [3:0] SPIMSC_CS_ONE = 4'h1;

  typedef struct packed {
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic [7:0] baud_divider_field;
    logic [7:0] between_transfer_delay;
  } spimsc_cfg_type;

  typedef struct packed {
    logic tx_holding_empty_flag;
    logic rx_holding_full_flag;
    logic transfer_done_flag;
    logic rx_overrun_flag;
  } spimsc_status_type;

  localparam spimsc_status_type SPIMSC_STATUS_RST = '{
    tx_holding_empty_flag: 1'b1,
    rx_holding_full_flag: 1'b0,
    transfer_done_flag: 1'b1,
    rx_overrun_flag: 1'b0
  };

  typedef enum logic [2:0] {
    SPIMSC_IDLE = 3'h1,
    SPIMSC_SHIFT = 3'h2,
    SPIMSC_GAP = 3'h4
  } spimsc_state_type;
endpackage
`default_nettype wire

// file: rtl/spimsc_buf.sv
`timescale 1ns/1ps
`default_nettype none
module spimsc_buf
  import spimsc_pkg::*;
#(
  parameter int WIDTH = SPIMSC_DATA_W,
  parameter int DEPTH = SPIMSC_BUF_DEPTH
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  // Skid structure only works for exactly two entries
  if (DEPTH != 2 || WIDTH < 1)
  begin : g_chk
    $error("spimsc_buf supports DEPTH 2 only");
  end

  logic spare_valid, next_spare_valid;
  logic [WIDTH-1:0] spare_data, next_spare_data;
  logic next_valid, next_ready;
  logic [WIDTH-1:0] next_data;
  logic push, pop;

  always_comb
  begin
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    next_valid = o_valid;
    next_data = o_data;
    next_spare_valid = spare_valid;
    next_spare_data = spare_data;
    if (pop || !o_valid)
    begin
      if (spare_valid)
      begin
        next_valid = 1'b1;
        next_data = spare_data;
        next_spare_valid = 1'b0;
      end
      else
      begin
        next_valid = push;
        next_data = push ? i_data : o_data;
      end
    end
    else if (push)
    begin
      next_spare_valid = 1'b1;
      next_spare_data = i_data;
    end
    // Ready from a flop, set from the next state, so it drops only when both slots are full
    next_ready = !next_spare_valid;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
      spare_valid <= 1'b0;
      spare_data <= '0;
      o_ready <= 1'b1;
    end
    else
    begin
      o_valid <= next_valid;
      o_data <= next_data;
      spare_valid <= next_spare_valid;
      spare_data <= next_spare_data;
      o_ready <= next_ready;
    end
  end
endmodule
`default_nettype wire

// file: rtl/spimsc_core.sv
// How it works
// R1 - Master: drives all chip selects and serial clock, MISO in, MOSI out.
// R2 - Slave: MISO out, MOSI in, chip select 0 is slave select input.
// R3 - Baud generator runs only as master; slave uses the external clock.
// R4 - Four modes from polarity and phase bits, mode 0 is polarity 0 phase 1.
// R5 - Polarity and phase of the chip-select config choose drive and sample edges.
// R6 - Both ends must share polarity and phase; master reconfigures per slave.
// R7 - Master, enabled: holding write starts transfer, word moves to shifter at once.
// R8 - Every bit shifted out also samples one bit into the same shifter.
// R9 - Chip-select field must be set before the holding register is written.
// R10 - Word written mid-transfer waits, then loads after received word is stored.
// R11 - Empty flag sets on move into shifter, clears on new holding write.
// R12 - Empty flag is the transmit DMA request.
// R13 - Done flag sets after last transfer and its between-transfer delay.
// R14 - Full flag sets when received word is stored, clears on read.
// R15 - Unread word overwritten sets overrun; status read clears it.
// R16 - One interrupt output for status events; the code raises it only for the full and overrun flags.
// R17 - Master clock divided by per-chip-select divider 1 to 255; zero forbidden.
// R18 - Slave takes clock only with slave select low, uses chip select 0 config.
// R19 - Words shift most significant bit first in both modes.
`timescale 1ns/1ps
`default_nettype none
module spimsc_core
  import spimsc_pkg::*;
#(
  parameter int DATA_W = SPIMSC_DATA_W
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_master_select_bit,
  input wire spimsc_cfg_type [SPIMSC_NUM_CS-1:0] i_cfg,
  input wire logic [1:0] i_chip_select_field,
  input wire logic i_tx_valid,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_tx_ready,
  output logic [DATA_W-1:0] o_rx_data,
  input wire logic i_rx_read,
  input wire logic i_status_read,
  output spimsc_status_type o_status,
  output logic o_tx_dma_req,
  output logic o_irq,
  output logic o_sclk,
  output logic o_sclk_oe,
  input wire logic i_sclk,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_miso,
  output logic [SPIMSC_NUM_CS-1:0] o_cs_n,
  output logic [SPIMSC_NUM_CS-1:0] o_cs_oe,
  input wire logic i_cs0_n
);
  localparam int HW = $clog2(2 * DATA_W);
  localparam logic [HW-1:0] LAST_HALF = HW'(2 * DATA_W - 1);
  localparam logic [HW-1:0] HALF_STEP = HW'(1);

  if (DATA_W < 2 || DATA_W > 32)
  begin : g_chk
    $error("spimsc_core DATA_W must be 2 to 32");
  end

  function automatic logic [SPIMSC_NUM_CS-1:0] cs_decode(input logic [1:0] idx);
    cs_decode = ~(SPIMSC_CS_ONE << idx);
  endfunction

  function automatic logic is_shift_half(input logic h0, input logic phase);
    is_shift_half = (h0 == phase);
  endfunction

  spimsc_state_type state, next_state;
  spimsc_status_type next_status;
  spimsc_cfg_type act_cfg;
  logic [DATA_W-1:0] shreg, next_shreg, hold, next_hold, next_rx_data, rx_word;
  logic [HW-1:0] half, next_half;
  logic [7:0] cnt, next_cnt, div_m1;
  logic [1:0] act_cs, next_act_cs;
  logic rx_bit, next_rx_bit, sclk_prev, next_sclk;
  logic next_irq, next_cs_oe_bit, next_miso_oe, next_mosi;
  logic [SPIMSC_NUM_CS-1:0] next_cs_n;
  logic master, slave_sel, baud_tick, bit_edge, in_bit, last, word_done, load_ok;
  logic buf_valid, hold_wr;
  logic [DATA_W-1:0] buf_data;

  // Holding register is fed through a two-entry skid so a stall loses no word
  spimsc_buf #(.WIDTH(DATA_W), .DEPTH(SPIMSC_BUF_DEPTH)) u_txbuf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_tx_valid),
    .i_data(i_tx_data),
    .o_ready(o_tx_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(o_status.tx_holding_empty_flag)
  );

  assign master = i_master_select_bit;
  assign slave_sel = !master && !i_cs0_n; // see R18
  assign act_cfg = master ? i_cfg[act_cs] : i_cfg[0]; // see R5 see R6 see R18
  // Zero divider is illegal; treated as one rather than stalling forever
  assign div_m1 = (act_cfg.baud_divider_field < SPIMSC_DIV_MIN) ? 8'h00
                : act_cfg.baud_divider_field - SPIMSC_DIV_MIN; // see R17
  assign baud_tick = master && state == SPIMSC_SHIFT && cnt == div_m1; // see R3
  assign bit_edge = master ? baud_tick
                  : (slave_sel && state == SPIMSC_SHIFT && i_sclk != sclk_prev);
  assign in_bit = master ? i_miso : i_mosi; // see R1 see R2
  assign last = half == LAST_HALF;
  assign word_done = bit_edge && last;
  assign hold_wr = buf_valid && o_status.tx_holding_empty_flag;
  assign load_ok = !o_status.tx_holding_empty_flag && (i_enable || !master);

  always_comb
  begin
    next_state = state;
    next_status = o_status;
    next_shreg = shreg;
    next_hold = hold;
    next_rx_data = o_rx_data;
    next_half = half;
    next_cnt = cnt;
    next_act_cs = act_cs;
    next_rx_bit = rx_bit;
    next_sclk = o_sclk;
    rx_word = shreg;
    if (i_rx_read)
    begin
      next_status.rx_holding_full_flag = 1'b0; // see R14
    end
    if (i_status_read)
    begin
      next_status.rx_overrun_flag = 1'b0; // see R15
    end
    if (hold_wr)
    begin
      next_hold = buf_data;
      next_status.tx_holding_empty_flag = 1'b0; // see R11
    end
    // Shift and sample on the edges picked by phase, MSB first
    if (bit_edge)
    begin
      if (is_shift_half(half[0], act_cfg.clock_phase_bit)) // see R4 see R5
      begin
        if (act_cfg.clock_phase_bit || half != '0)
        begin
          next_shreg = {shreg[DATA_W-2:0], rx_bit}; // see R8 see R19
        end
      end
      else
      begin
        next_rx_bit = in_bit; // see R8
        if (last)
        begin
          next_shreg = {shreg[DATA_W-2:0], in_bit};
        end
      end
      rx_word = next_shreg;
      next_half = half + HALF_STEP;
    end
    case (state)
      SPIMSC_IDLE:
      begin
        if (master)
        begin
          // Idle level follows the target, not the last chip select used
          next_sclk = i_cfg[i_chip_select_field].clock_polarity_bit; // see R5
        end
        if ((master && i_enable) || slave_sel)
        begin
          next_half = '0;
          next_cnt = '0;
          next_state = (master && !load_ok) ? SPIMSC_IDLE : SPIMSC_SHIFT;
          if (load_ok)
          begin
            next_shreg = hold; // see R7
            next_status.tx_holding_empty_flag = 1'b1; // see R11
            next_status.transfer_done_flag = 1'b0;
            next_act_cs = master ? i_chip_select_field : 2'h0; // see R9
          end
        end
      end
      SPIMSC_SHIFT:
      begin
        if (bit_edge)
        begin
          next_cnt = '0;
          if (master)
          begin
            next_sclk = !o_sclk;
          end
          if (last)
          begin
            next_rx_data = rx_word; // see R10
            next_status.rx_holding_full_flag = 1'b1; // see R14
            if (o_status.rx_holding_full_flag && !i_rx_read)
            begin
              next_status.rx_overrun_flag = 1'b1; // see R15
            end
            next_half = '0;
            if (master)
            begin
              next_state = SPIMSC_GAP;
            end
            else if (load_ok)
            begin
              next_shreg = hold;
              next_status.tx_holding_empty_flag = 1'b1;
            end
          end
        end
        else if (master)
        begin
          next_cnt = cnt + SPIMSC_CNT_STEP; // see R17
        end
        if (!master && !slave_sel)
        begin
          // Slave select released mid-word drops the partial word
          next_state = SPIMSC_IDLE;
        end
      end
      SPIMSC_GAP:
      begin
        if (!master)
        begin
          next_state = SPIMSC_IDLE;
        end
        else if (cnt >= act_cfg.between_transfer_delay)
        begin
          next_cnt = '0;
          if (load_ok)
          begin
            next_shreg = hold; // see R10
            next_status.tx_holding_empty_flag = 1'b1;
            next_act_cs = i_chip_select_field;
            next_sclk = i_cfg[i_chip_select_field].clock_polarity_bit; // see R5
            next_state = SPIMSC_SHIFT;
          end
          else
          begin
            next_status.transfer_done_flag = 1'b1; // see R13
            next_state = SPIMSC_IDLE;
          end
        end
        else
        begin
          next_cnt = cnt + SPIMSC_CNT_STEP;
        end
      end
      default:
      begin
        next_state = SPIMSC_IDLE;
      end
    endcase
    next_cs_oe_bit = master; // see R1 see R2
    next_miso_oe = slave_sel; // see R2
    // Phase 0 last sample lands on a trailing edge; MOSI held there for hold time
    next_mosi = (bit_edge && last && !act_cfg.clock_phase_bit) ? o_mosi
              : next_shreg[DATA_W-1]; // see R19
    next_cs_n = (master && next_state != SPIMSC_IDLE) ? cs_decode(next_act_cs)
              : SPIMSC_CS_IDLE;
    next_irq = next_status.rx_holding_full_flag || next_status.rx_overrun_flag; // see R16
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= SPIMSC_IDLE;
      o_status <= SPIMSC_STATUS_RST;
      shreg <= '0;
      hold <= '0;
      o_rx_data <= '0;
      half <= '0;
      cnt <= '0;
      act_cs <= 2'h0;
      rx_bit <= 1'b0;
      sclk_prev <= 1'b0;
      o_sclk <= 1'b0;
      o_sclk_oe <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_mosi <= 1'b0;
      o_miso_oe <= 1'b0;
      o_cs_oe <= '0;
      o_cs_n <= SPIMSC_CS_IDLE;
      o_tx_dma_req <= 1'b1;
      o_irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_status <= next_status;
      shreg <= next_shreg;
      hold <= next_hold;
      o_rx_data <= next_rx_data;
      half <= next_half;
      cnt <= next_cnt;
      act_cs <= next_act_cs;
      rx_bit <= next_rx_bit;
      sclk_prev <= i_sclk;
      o_sclk <= next_sclk;
      o_sclk_oe <= next_cs_oe_bit;
      o_mosi_oe <= next_cs_oe_bit;
      o_mosi <= next_mosi;
      o_miso_oe <= next_miso_oe;
      o_cs_oe <= {SPIMSC_NUM_CS{next_cs_oe_bit}};
      o_cs_n <= next_cs_n;
      o_tx_dma_req <= next_status.tx_holding_empty_flag; // see R12
      o_irq <= next_irq;
    end
  end

  assign o_miso = shreg[DATA_W-1];

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_master_start;
    master && i_enable && state == SPIMSC_IDLE && !o_status.tx_holding_empty_flag;
  endsequence

  sequence s_last_gap;
    master && state == SPIMSC_GAP && cnt >= act_cfg.between_transfer_delay
      && o_status.tx_holding_empty_flag;
  endsequence

  AST_MASTER_PINS: assert property (master ##1 master |-> o_sclk_oe && o_mosi_oe // see R1
    && o_cs_oe == SPIMSC_CS_IDLE && !o_miso_oe)
    else $error("master pin enables wrong");
  AST_SLAVE_PINS: assert property (!master ##1 !master |-> !o_sclk_oe && !o_mosi_oe // see R2
    && o_cs_oe == '0 && o_miso_oe == $past(!i_cs0_n))
    else $error("slave pin enables wrong");
  AST_NO_BAUD_SLAVE: assert property (!master |-> !baud_tick) // see R3
    else $error("baud generator active as slave");
  AST_EDGE_PHASE: assert property (bit_edge && next_shreg != shreg && !last // see R4
    |-> half[0] == act_cfg.clock_phase_bit)
    else $error("shift on wrong clock edge");
  AST_START: assert property (s_master_start |=> state == SPIMSC_SHIFT // see R7
    && o_status.tx_holding_empty_flag && shreg == $past(hold) && o_cs_n != SPIMSC_CS_IDLE)
    else $error("master transfer did not start");
  AST_RX_STORE: assert property (word_done |=> o_status.rx_holding_full_flag // see R10
    && o_rx_data == $past(rx_word))
    else $error("received word not stored");
  AST_EMPTY_CLR: assert property (hold_wr |=> !o_status.tx_holding_empty_flag // see R11
    ##1 o_tx_dma_req == o_status.tx_holding_empty_flag)
    else $error("empty flag not cleared on write");
  AST_DONE: assert property (s_last_gap |=> o_status.transfer_done_flag // see R13
    && state == SPIMSC_IDLE && o_cs_n == SPIMSC_CS_IDLE)
    else $error("done flag not set after last transfer");
  AST_OVERRUN: assert property (word_done && o_status.rx_holding_full_flag && !i_rx_read // see R15
    |=> o_status.rx_overrun_flag)
    else $error("overrun not flagged");
  AST_SLAVE_SEL: assert property (!master && i_cs0_n |=> state != SPIMSC_SHIFT) // see R18
    else $error("slave shifting without select");
endmodule
`default_nettype wire

// file: dv/spimsc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module spimsc_peer
  import spimsc_pkg::*;
(
  input wire logic i_sel,
  input wire logic i_sclk,
  input wire logic i_clock_polarity_bit,
  input wire logic i_phase,
  input wire logic i_mosi,
  input wire logic [SPIMSC_DATA_W-1:0] i_reply,
  output logic o_miso
);
  localparam int W = SPIMSC_DATA_W;
  logic [W-1:0] sh;
  logic [W-1:0] rx;
  int cnt;
  logic [W-1:0] log_q[$];
  initial o_miso = 1'b0;
  // Released line has no pull, so show the inverse of the last bit
  always @(i_sel)
  begin
    if (i_sel)
    begin
      sh = i_reply;
      cnt = 0;
      o_miso = sh[W-1];
    end
    else
      o_miso = ~o_miso;
  end
  // Same polarity and phase as the master
  always @(i_sclk)
  begin
    if (i_sel)
    begin
      if ((i_sclk != i_clock_polarity_bit) == i_phase)
      begin
        rx = {rx[W-2:0], i_mosi};
        cnt++;
        if (cnt == W)
        begin
          log_q.push_back(rx);
          cnt = 0;
          if (!i_phase)
            sh = i_reply;
        end
      end
      else if (cnt != 0)
        sh = sh << 1;
      else if (i_phase)
        sh = i_reply;
      o_miso = sh[W-1];
    end
  end
endmodule
`default_nettype wire

// file: dv/test_spi_master_slave_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_slave_core
  import spimsc_pkg::*;
;
  localparam int W = SPIMSC_DATA_W;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic msel, txv, rxr, str, sclk_in, mosi_in, cs0_n, miso_in, en;
  logic tx_ready, dma, irq, sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe;
  spimsc_cfg_type [SPIMSC_NUM_CS-1:0] cfg;
  spimsc_status_type st;
  logic [1:0] csf;
  logic [3:0] cs_n, cs_oe;
  logic [W-1:0] txd, rxd, reply;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  spimsc_core i_spimsc_core (.i_clk(clk), .i_rst(rst), .i_enable(en),
    .i_master_select_bit(msel), .i_cfg(cfg), .i_chip_select_field(csf),
    .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(tx_ready), .o_rx_data(rxd),
    .i_rx_read(rxr), .i_status_read(str), .o_status(st), .o_tx_dma_req(dma),
    .o_irq(irq), .o_sclk(sclk), .o_sclk_oe(sclk_oe), .i_sclk(sclk_in),
    .o_mosi(mosi), .o_mosi_oe(mosi_oe), .i_mosi(mosi_in), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_miso(miso_in), .o_cs_n(cs_n), .o_cs_oe(cs_oe),
    .i_cs0_n(cs0_n));
  spimsc_peer i_spimsc_peer (.i_sel(msel && cs_n != 4'hF), .i_sclk(sclk),
    .i_clock_polarity_bit(cfg[csf].clock_polarity_bit), .i_phase(cfg[csf].clock_phase_bit),
    .i_mosi(mosi), .i_reply(reply), .o_miso(miso_in));
  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cycle ceiling covers the slowest divider with margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  function automatic logic [3:0] cs_exp(input int x);
    return ~(4'h1 << x);
  endfunction
  // Caller drops valid, so back-to-back words keep it high
  task automatic send(input logic [W-1:0] w);
    txv = 1'b1;
    txd = w;
    while (tx_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
  endtask
  task automatic clear_flags(input logic ovr);
    rxr = 1'b1;
    @(negedge clk);
    rxr = 1'b0;
    chk({st.rx_holding_full_flag, st.rx_overrun_flag, irq}, {1'b0, ovr, ovr}, "rx read");
    str = 1'b1;
    @(negedge clk);
    str = 1'b0;
    chk({st.rx_overrun_flag, irq}, 2'h0, "status read");
  endtask
  task automatic burst(input int i);
    logic [W-1:0] w[3];
    int n, k, idx, dly;
    n = 1 + i % 3;
    idx = $urandom % 4;
    dly = $urandom % 4;
    @(negedge clk);
    cfg[idx] = '{i[1], ~i[0], (i == 11) ? 8'hFF : 8'(1 + $urandom % 3), 8'(dly)};
    csf = idx[1:0];
    reply = W'($urandom);
    i_spimsc_peer.log_q.delete();
    en = (i != 0);
    for (k = 0; k < n; k++)
    begin
      w[k] = W'($urandom);
      send(w[k]);
    end
    txv = 1'b0;
    if (i == 0)
    begin
      repeat (6) @(negedge clk);
      chk({cs_n, st.tx_holding_empty_flag, dma}, 6'h3C, "held while disabled");
      en = 1'b1;
    end
    for (k = 0; k < 10 && cs_n === 4'hF; k++)
      @(negedge clk);
    chk(cs_n, cs_exp(idx), "chip select");
    chk({sclk_oe, mosi_oe, miso_oe, cs_oe}, 7'h6F, "master pins");
    while (st.rx_holding_full_flag !== 1'b1)
      @(negedge clk);
    if (n == 1)
    begin
      for (k = 0; st.transfer_done_flag !== 1'b1 && k < 300; k++)
        @(negedge clk);
      chk(k, dly + 1, "done delay");
    end
    while (st.transfer_done_flag !== 1'b1)
      @(negedge clk);
    chk(i_spimsc_peer.log_q.size(), n, "word count");
    for (k = 0; k < n; k++)
      chk(i_spimsc_peer.log_q[k], w[k], "mosi word");
    chk(rxd, reply, "miso word");
    chk(st, {3'h7, 1'(n > 1)}, "status");
    chk({dma, irq, cs_n}, 6'h3F, "dma irq");
    clear_flags(n > 1);
  endtask
  initial
  begin
    logic [W-1:0] sw, tw, got;
    void'($urandom(36108));
    {msel, txv, rxr, str, sclk_in, mosi_in, cs0_n} = 7'h41;
    en = 1'b1;
    csf = 2'h0;
    txd = '0;
    reply = '0;
    for (int c = 0; c < SPIMSC_NUM_CS; c++)
      cfg[c] = '{1'b0, 1'b1, 8'h01, 8'h00};
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk({st, dma, irq, cs_n}, {SPIMSC_STATUS_RST, 6'h2F}, "reset");
    for (int i = 0; i < 12; i++)
      burst(i);
    msel = 1'b0;
    // Slave runs mode 0 from chip select 0, which bursts may have changed
    cfg[0] = '{1'b0, 1'b1, 8'h01, 8'h00};
    @(negedge clk);
    chk({sclk_oe, mosi_oe, miso_oe, cs_oe}, 7'h0, "slave pins");
    sw = W'($urandom);
    tw = W'($urandom);
    send(tw);
    txv = 1'b0;
    // Clock edges while deselected must not be counted
    sclk_in = 1'b1;
    repeat (2) @(negedge clk);
    sclk_in = 1'b0;
    repeat (2) @(negedge clk);
    chk({st.rx_holding_full_flag, miso_oe}, 2'h0, "unselected clock");
    cs0_n = 1'b0;
    mosi_in = sw[W-1];
    repeat (4) @(negedge clk);
    chk(miso_oe, 1'b1, "slave drive");
    // Slow external clock, four system clocks per half bit
    for (int b = W - 1; b >= 0; b--)
    begin
      got[b] = miso;
      sclk_in = 1'b1;
      repeat (4) @(negedge clk);
      sclk_in = 1'b0;
      mosi_in = (b > 0) ? sw[b-1] : 1'b0;
      repeat (4) @(negedge clk);
    end
    chk(got, tw, "slave miso");
    chk({rxd, st.rx_holding_full_flag}, {sw, 1'b1}, "slave rx");
    cs0_n = 1'b1;
    tally_and_finish;
  end
endmodule
`default_nettype wire
